/* File: design/its_regs.svh */
// register offsets, field positions, table indices, limits and reset values for the inband tone unit
`ifndef ITS_REGS_SVH
`define ITS_REGS_SVH

`define ITS_ADDR_MODE     8'hC1
`define ITS_ADDR_TX       8'hC3
`define ITS_ADDR_IRQ      8'hC6
`define ITS_ADDR_PROG     8'hC8
`define ITS_ADDR_TSTAT    8'hCC

`define ITS_MODE_IB_HI    11
`define ITS_MODE_IB_LO    9
`define ITS_MODE_DTMF_EN  8
`define ITS_MODE_IRQ_EN   0

`define ITS_IRQ_INBAND    13
`define ITS_IRQ_DTMF      12
`define ITS_TST_DTMF      10

`define ITS_TX_DTMF       10
`define ITS_TX_SINGLE     9
`define ITS_TX_TWIST      8
`define ITS_PROG_PTR      15

`define ITS_FREQ_MIN      12'h120
`define ITS_FREQ_MAX      12'hBB8
`define ITS_TWIST_MUL     20'h000CB

`define ITS_TBL_N         24
`define ITS_IDX_LEVEL     5'h00
`define ITS_IDX_SEL0      5'h02
`define ITS_IDX_SEL_LAST  5'h11
`define ITS_IDX_CUS0      5'h12
`define ITS_IDX_CUS_LAST  5'h15
`define ITS_IDX_BW        5'h16
`define ITS_IDX_THR       5'h17
`define ITS_IDX_LAST      5'h17

`define ITS_LEVEL_DEF     12'h800
`define ITS_CUSTOM_DEF    12'h000
`define ITS_BW_DEF        12'h01E
`define ITS_THR_DEF       12'h100

`endif

/* File: design/its_pkg.sv */
// types shared by the inband tone unit
package its_pkg;

	typedef enum logic [2:0] {
		ITS_IB_OFF,
		ITS_IB_SELCALL,
		ITS_IB_CUSTOM,
		ITS_IB_ALL
	} its_ibmode_e;

	typedef enum logic {
		ITS_SC_IDLE,
		ITS_SC_RUN
	} its_scan_e;

	typedef struct packed {
		logic       set;
		logic [3:0] code;
	} its_code_s;

	typedef struct packed {
		logic        on;
		logic [11:0] f_lo;
		logic [11:0] f_hi;
		logic [11:0] lvl_lo;
		logic [11:0] lvl_hi;
	} its_txout_s;

endpackage

/* File: design/its_scan.sv */
// sequential first-match search over a range of the tone table
`timescale 1ns/1ps
`default_nettype none
module its_scan
	import its_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [11:0] freq,
	input  wire logic [11:0] bw,
	input  wire logic [4:0]  first,
	input  wire logic [4:0]  last,
	input  wire logic [11:0] entry,
	output logic      [4:0]  idx,
	output logic             busy,
	output logic             done,
	output logic             hit,
	output logic      [4:0]  hit_idx
);
	its_scan_e   st_r;
	logic [4:0]  idx_r;
	logic [4:0]  last_r;
	logic [11:0] freq_r;
	logic [11:0] diff;
	logic        near;

	assign idx  = idx_r;
	assign busy = (st_r == ITS_SC_RUN);
	assign diff = (entry > freq_r) ? entry - freq_r : freq_r - entry;
	assign near = (diff <= bw);

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r    <= ITS_SC_IDLE;
			idx_r   <= 5'h00;
			last_r  <= 5'h00;
			freq_r  <= 12'h000;
			done    <= 1'b0;
			hit     <= 1'b0;
			hit_idx <= 5'h00;
		end else begin
			done <= 1'b0;
			case (st_r)
				ITS_SC_IDLE: begin
					if (start) begin
						idx_r  <= first;
						last_r <= last;
						freq_r <= freq;
						st_r   <= ITS_SC_RUN;
					end
				end
				default: begin
					// lowest index wins, table order is priority
					if (near || idx_r == last_r) begin
						done    <= 1'b1;
						hit     <= near;
						hit_idx <= idx_r;
						st_r    <= ITS_SC_IDLE;
					end else begin
						idx_r <= idx_r + 5'h01;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: design/its_inband.sv */
// inband selcall, custom tone and dtmf detect and generate unit
`timescale 1ns/1ps
`default_nettype none
`include "its_regs.svh"
module its_inband
	import its_pkg::*;
(
	input  wire logic        CLK_SYS,
	input  wire logic        RESET,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [15:0] REG_RDATA,
	input  wire logic        RX_TONE_STB,
	input  wire logic [11:0] RX_TONE_FREQ,
	input  wire logic [11:0] RX_TONE_LEVEL,
	input  wire logic        RX_DTMF_STB,
	input  wire logic [11:0] RX_DTMF_LO_FREQ,
	input  wire logic [11:0] RX_DTMF_HI_FREQ,
	input  wire logic [11:0] RX_DTMF_LEVEL,
	output its_txout_s       TX_OUT,
	output logic             IRQ
);
	logic [11:0] tbl_r [0:`ITS_TBL_N-1];
	logic [4:0]  ptr_r;
	logic [15:0] mode_r;
	logic [15:0] tx_r;
	logic [15:0] irq_r;
	logic [15:0] tstat_r;
	its_code_s   ib_last_r;
	logic [4:0]  dtmf_last_r;
	logic        wr_mode, wr_tx, wr_prog, rd_irq;
	logic        prog_ok;
	its_ibmode_e ib_mode;
	logic        ib_on, irq_en, dtmf_en;
	logic [4:0]  sc_first, sc_last, sc_idx, sc_hit_idx;
	logic        sc_busy, sc_done, sc_hit, sc_start;
	logic [11:0] bw, thr;
	logic        ib_upd, ib_chg;
	its_code_s   ib_code;
	logic        dtmf_hit, dtmf_new;
	logic [3:0]  dtmf_code;
	logic [15:0] irq_set;
	its_txout_s  txo_nxt;
	logic [19:0] tw_prod;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);

	function automatic logic [11:0] tbl_default(input logic [4:0] i);
		case (i)
			5'h00: return `ITS_LEVEL_DEF;
			5'h02: return 12'd1981;
			5'h03: return 12'd1124;
			5'h04: return 12'd1197;
			5'h05: return 12'd1275;
			5'h06: return 12'd1358;
			5'h07: return 12'd1446;
			5'h08: return 12'd1540;
			5'h09: return 12'd1640;
			5'h0A: return 12'd1747;
			5'h0B: return 12'd1860;
			5'h0C: return 12'd1055;
			5'h0D: return 12'd930;
			5'h0E: return 12'd2247;
			5'h0F: return 12'd991;
			5'h10: return 12'd2110;
			5'h11: return 12'd2400;
			5'h16: return `ITS_BW_DEF;
			5'h17: return `ITS_THR_DEF;
			default: return `ITS_CUSTOM_DEF;
		endcase
	endfunction

	function automatic logic is_freq_idx(input logic [4:0] i);
		return (i >= `ITS_IDX_SEL0) && (i <= `ITS_IDX_CUS_LAST);
	endfunction

	function automatic logic [11:0] row_freq(input logic [1:0] r);
		case (r)
			2'h0: return 12'd697;
			2'h1: return 12'd770;
			2'h2: return 12'd852;
			default: return 12'd941;
		endcase
	endfunction

	function automatic logic [11:0] col_freq(input logic [1:0] c);
		case (c)
			2'h0: return 12'd1209;
			2'h1: return 12'd1336;
			2'h2: return 12'd1477;
			default: return 12'd1633;
		endcase
	endfunction

	// keypad row of a dtmf code
	function automatic logic [1:0] dtmf_row(input logic [3:0] k);
		case (k)
			4'h1, 4'h2, 4'h3, 4'hD: return 2'h0;
			4'h4, 4'h5, 4'h6, 4'hE: return 2'h1;
			4'h7, 4'h8, 4'h9, 4'hF: return 2'h2;
			default: return 2'h3;
		endcase
	endfunction

	function automatic logic [1:0] dtmf_col(input logic [3:0] k);
		case (k)
			4'h1, 4'h4, 4'h7, 4'hB: return 2'h0;
			4'h2, 4'h5, 4'h8, 4'hA: return 2'h1;
			4'h3, 4'h6, 4'h9, 4'hC: return 2'h2;
			default: return 2'h3;
		endcase
	endfunction

	function automatic logic near_f(input logic [11:0] a, input logic [11:0] b,
			input logic [11:0] w);
		return ((a > b) ? a - b : b - a) <= w;
	endfunction

	// register strobes
	always_comb begin
		wr_mode = 1'b0;
		wr_tx   = 1'b0;
		wr_prog = 1'b0;
		rd_irq  = REG_RD && (REG_ADDR == `ITS_ADDR_IRQ);
		if (REG_WR && REG_ADDR == `ITS_ADDR_MODE) begin
			wr_mode = 1'b1;
		end else if (REG_WR && REG_ADDR == `ITS_ADDR_TX) begin
			wr_tx = 1'b1;
		end else if (REG_WR && REG_ADDR == `ITS_ADDR_PROG) begin
			wr_prog = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			REG_RDATA <= 16'h0000;
		end else if (REG_RD && REG_ADDR == `ITS_ADDR_IRQ) begin
			REG_RDATA <= irq_r;
		end else if (REG_RD && REG_ADDR == `ITS_ADDR_TSTAT) begin
			REG_RDATA <= tstat_r;
		end else if (REG_RD) begin
			REG_RDATA <= 16'h0000;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			mode_r <= 16'h0000;
		end else if (wr_mode) begin
			mode_r <= REG_WDATA;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			tx_r <= 16'h0000;
		end else if (wr_tx) begin
			tx_r <= REG_WDATA;
		end
	end

	// programming port: pointer word, then data words with auto increment
	assign prog_ok = !is_freq_idx(ptr_r) ||
		(REG_WDATA[11:0] >= `ITS_FREQ_MIN && REG_WDATA[11:0] <= `ITS_FREQ_MAX);

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			ptr_r <= 5'h00;
		end else if (wr_prog && REG_WDATA[`ITS_PROG_PTR]) begin
			ptr_r <= REG_WDATA[4:0];
		end else if (wr_prog) begin
			ptr_r <= (ptr_r >= `ITS_IDX_LAST) ? 5'h00 : ptr_r + 5'h01;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			for (int i = 0; i < `ITS_TBL_N; i++) begin
				tbl_r[i] <= tbl_default(5'(i));
			end
		end else if (wr_prog && !REG_WDATA[`ITS_PROG_PTR] && prog_ok &&
				ptr_r <= `ITS_IDX_LAST) begin
			tbl_r[ptr_r] <= REG_WDATA[11:0];
		end
	end

	assign ib_mode = its_ibmode_e'(mode_r[`ITS_MODE_IB_HI:`ITS_MODE_IB_LO]);
	assign irq_en  = mode_r[`ITS_MODE_IRQ_EN];
	assign dtmf_en = mode_r[`ITS_MODE_DTMF_EN];
	assign bw      = tbl_r[`ITS_IDX_BW];
	assign thr     = tbl_r[`ITS_IDX_THR];

	always_comb begin
		ib_on    = 1'b1;
		sc_first = `ITS_IDX_SEL0;
		sc_last  = `ITS_IDX_CUS_LAST;
		case (ib_mode)
			ITS_IB_SELCALL: sc_last = `ITS_IDX_SEL_LAST;
			ITS_IB_CUSTOM: sc_first = `ITS_IDX_CUS0;
			ITS_IB_ALL: ib_on = 1'b1;
			default: ib_on = 1'b0;
		endcase
	end

	// detection is fed from the receive filter strobe only, independent of audio paths
	assign sc_start = RX_TONE_STB && ib_on && !sc_busy &&
		(RX_TONE_LEVEL >= thr);

	its_scan u_scan (
		.clk     (CLK_SYS),
		.rst     (RESET),
		.start   (sc_start),
		.freq    (RX_TONE_FREQ),
		.bw      (bw),
		.first   (sc_first),
		.last    (sc_last),
		.entry   (tbl_r[sc_idx]),
		.idx     (sc_idx),
		.busy    (sc_busy),
		.done    (sc_done),
		.hit     (sc_hit),
		.hit_idx (sc_hit_idx)
	);

	// repeat code 14 passes through like any other code
	always_comb begin
		ib_upd  = 1'b0;
		ib_code = '0;
		if (sc_done && sc_hit && sc_hit_idx <= `ITS_IDX_SEL_LAST) begin
			ib_upd  = 1'b1;
			ib_code = {1'b1, 4'(sc_hit_idx - `ITS_IDX_SEL0)};
		end else if (sc_done && sc_hit) begin
			ib_upd  = 1'b1;
			ib_code = {1'b0, 4'(sc_hit_idx - `ITS_IDX_SEL_LAST)};
		end else if (sc_done) begin
			ib_upd  = 1'b1;
			ib_code = {1'b0, 4'hF};
		end else if (RX_TONE_STB && ib_on && !sc_busy && RX_TONE_LEVEL < thr) begin
			ib_upd  = 1'b1;
		end
	end

	assign ib_chg = ib_upd && (ib_code != ib_last_r);

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			ib_last_r <= '0;
		end else if (ib_upd) begin
			ib_last_r <= ib_code;
		end
	end

	// dtmf pair match, first row and column in table order
	always_comb begin
		logic       rh, ch;
		logic [1:0] r, c;
		rh = 1'b0;
		ch = 1'b0;
		r  = 2'h0;
		c  = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (near_f(RX_DTMF_LO_FREQ, row_freq(2'(i)), bw)) begin
				rh = 1'b1;
				r  = 2'(i);
			end
			if (near_f(RX_DTMF_HI_FREQ, col_freq(2'(i)), bw)) begin
				ch = 1'b1;
				c  = 2'(i);
			end
		end
		dtmf_code = 4'h0;
		for (int k = 0; k < 16; k++) begin
			if (dtmf_row(4'(k)) == r && dtmf_col(4'(k)) == c) begin
				dtmf_code = 4'(k);
			end
		end
		dtmf_hit = RX_DTMF_STB && dtmf_en && rh && ch && RX_DTMF_LEVEL >= thr;
	end

	assign dtmf_new = dtmf_hit && (dtmf_last_r != {1'b1, dtmf_code});

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			dtmf_last_r <= 5'h00;
		end else if (dtmf_hit) begin
			dtmf_last_r <= {1'b1, dtmf_code};
		end else if (RX_DTMF_STB) begin
			dtmf_last_r <= 5'h00;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			tstat_r <= 16'h0000;
		end else if (dtmf_new) begin
			tstat_r <= {1'b0, dtmf_code, 1'b1, 10'h000};
		end else if (ib_chg) begin
			tstat_r <= {ib_code, 11'h000};
		end
	end

	always_comb begin
		irq_set = 16'h0000;
		irq_set[`ITS_IRQ_INBAND] = ib_chg && irq_en;
		irq_set[`ITS_IRQ_DTMF]   = dtmf_new && irq_en;
	end

	// clear on read; a new event in the read cycle survives
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			irq_r <= 16'h0000;
		end else begin
			irq_r <= (rd_irq ? 16'h0000 : irq_r) | irq_set;
		end
	end

	assign IRQ = |irq_r;

	// transmit generator settings
	assign tw_prod = 20'(tbl_r[`ITS_IDX_LEVEL]) * `ITS_TWIST_MUL;

	always_comb begin
		txo_nxt        = '0;
		txo_nxt.lvl_lo = tbl_r[`ITS_IDX_LEVEL];
		txo_nxt.lvl_hi = tbl_r[`ITS_IDX_LEVEL];
		if (tx_r[`ITS_TX_DTMF]) begin
			txo_nxt.on   = 1'b1;
			txo_nxt.f_lo = row_freq(dtmf_row(tx_r[3:0]));
			txo_nxt.f_hi = col_freq(dtmf_col(tx_r[3:0]));
			if (tx_r[`ITS_TX_TWIST]) begin
				txo_nxt.lvl_lo = tw_prod[19:8];
			end
			if (tx_r[`ITS_TX_SINGLE] && !tx_r[3]) begin
				txo_nxt.f_hi   = 12'h000;
				txo_nxt.lvl_hi = 12'h000;
			end else if (tx_r[`ITS_TX_SINGLE]) begin
				txo_nxt.f_lo   = 12'h000;
				txo_nxt.lvl_lo = 12'h000;
			end
		end else if (tx_r[15]) begin
			txo_nxt.on     = 1'b1;
			txo_nxt.f_lo   = tbl_r[`ITS_IDX_SEL0 + {1'b0, tx_r[14:11]}];
			txo_nxt.lvl_hi = 12'h000;
		end else if (tx_r[14:11] >= 4'h1 && tx_r[14:11] <= 4'h4) begin
			txo_nxt.on     = 1'b1;
			txo_nxt.f_lo   = tbl_r[`ITS_IDX_SEL_LAST + {1'b0, tx_r[14:11]}];
			txo_nxt.lvl_hi = 12'h000;
		end else begin
			txo_nxt.lvl_lo = 12'h000;
			txo_nxt.lvl_hi = 12'h000;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			TX_OUT <= '0;
		end else begin
			TX_OUT <= txo_nxt;
		end
	end

	chk_eea_default: assert property ($fell(RESET) |-> tbl_r[2] == 12'd1981)
		else $error("selcall code 0 default lost");
	chk_prog_range: assert property (wr_prog && !REG_WDATA[15] && is_freq_idx(ptr_r) &&
		REG_WDATA[11:0] > `ITS_FREQ_MAX |=> tbl_r[$past(ptr_r)] == $past(tbl_r[ptr_r]))
		else $error("out of range frequency stored");
	chk_mode_field: assert property (wr_mode |=> ib_mode == its_ibmode_e'($past(REG_WDATA[11:9])))
		else $error("mode field not taken from bits 11 to 9");
	chk_scan_bound: assert property (sc_start |-> ##[2:21] sc_done)
		else $error("table scan did not finish in time");
	chk_irq_change: assert property (ib_chg && irq_en |=> irq_r[13])
		else $error("tone change did not raise status bit 13");
	chk_irq_quiet: assert property (!ib_chg && !dtmf_new && !rd_irq |=> $stable(irq_r))
		else $error("status changed without an event");
	chk_dtmf_flag: assert property (dtmf_new |=> tstat_r[10] && tstat_r[14:11] == $past(dtmf_code))
		else $error("dtmf result not placed in tone status");
	chk_dtmf_over: assert property (dtmf_new && ib_chg |=> tstat_r[10])
		else $error("inband value beat dtmf value");
	chk_tx_hold: assert property (!wr_tx && !wr_prog ##1 !wr_tx && !wr_prog |=> $stable(TX_OUT))
		else $error("transmit tone changed without a write");
	chk_single_lo: assert property (tx_r[10] && tx_r[9] && !tx_r[3] && $stable(tx_r)
		|=> TX_OUT.f_hi == 12'h000 && TX_OUT.f_lo != 12'h000)
		else $error("single tone did not keep only the low tone");
	chk_twist_lvl: assert property (tx_r[10] && tx_r[8] && !tx_r[9] && $stable(tx_r) &&
		$stable(tbl_r[0]) |=> TX_OUT.lvl_lo < TX_OUT.lvl_hi || TX_OUT.lvl_hi == 12'h000)
		else $error("twist did not lower the low tone");
endmodule
`default_nettype wire

/* File: tb/its_host.sv */
// host controller model driving the register strobe bus
`timescale 1ns/1ps
`default_nettype none
module its_host (
	input  wire logic        clk,
	input  wire logic [15:0] rdata,
	output logic      [7:0]  addr,
	output logic      [15:0] wdata,
	output logic             wr,
	output logic             rd
);
	// host never drives audio, data or sub-audio paths around tone work
	initial begin
		addr = 8'h00;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
	end

	// one strobe per access; put inverts the released data lines and keeps the address, get inverts the released address
	task automatic put(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask

	task automatic get(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		addr <= ~a;
		#1;
		d = rdata;
	endtask
endmodule
`default_nettype wire

/* File: tb/its_inband_bench.sv */
// self-checking bench for the inband tone unit
`timescale 1ns/1ps
`default_nettype none
`include "its_regs.svh"
module its_inband_bench
	import its_pkg::*;
;
	localparam logic [11:0] LO_TAB [16] = '{12'h3AD, 12'h2B9, 12'h2B9, 12'h2B9, 12'h302,
		12'h302, 12'h302, 12'h354, 12'h354, 12'h354, 12'h3AD, 12'h3AD, 12'h3AD, 12'h2B9,
		12'h302, 12'h354};
	localparam logic [11:0] HI_TAB [16] = '{12'h661, 12'h4B9, 12'h538, 12'h5C5, 12'h4B9,
		12'h538, 12'h5C5, 12'h4B9, 12'h538, 12'h5C5, 12'h538, 12'h4B9, 12'h5C5, 12'h661,
		12'h661, 12'h661};
	localparam logic [11:0] SEL_TAB [16] = '{12'h7BD, 12'h464, 12'h4AD, 12'h4FB, 12'h54E,
		12'h5A6, 12'h604, 12'h668, 12'h6D3, 12'h744, 12'h41F, 12'h3A2, 12'h8C7, 12'h3DF,
		12'h83E, 12'h960};

	logic        clk_sys = 1'b0;
	logic        reset   = 1'b1;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic [15:0] rv;
	logic        reg_wr;
	logic        reg_rd;
	logic        irq;
	logic        tone_stb = 1'b0;
	logic        dtmf_stb = 1'b0;
	logic [11:0] tone_freq = 12'h000;
	logic [11:0] tone_lvl  = 12'h000;
	logic [11:0] lo_f      = 12'h000;
	logic [11:0] hi_f      = 12'h000;
	logic [11:0] dtmf_lvl  = 12'h000;
	its_txout_s  tx_out;
	int          bad_count    = 0;
	int          total_checks = 0;
	int          cycles       = 0;

	its_host its_host_i (.clk(clk_sys), .rdata(reg_rdata), .addr(reg_addr),
		.wdata(reg_wdata), .wr(reg_wr), .rd(reg_rd));

	its_inband its_inband_i (.CLK_SYS(clk_sys), .RESET(reset), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.RX_TONE_STB(tone_stb), .RX_TONE_FREQ(tone_freq), .RX_TONE_LEVEL(tone_lvl),
		.RX_DTMF_STB(dtmf_stb), .RX_DTMF_LO_FREQ(lo_f), .RX_DTMF_HI_FREQ(hi_f),
		.RX_DTMF_LEVEL(dtmf_lvl), .TX_OUT(tx_out), .IRQ(irq));

	always #5 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 10000) begin
			bad_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (bad_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		its_host_i.put(a, d);
	endtask

	task automatic rd_chk(input string n, input logic [7:0] a, input logic [15:0] e);
		its_host_i.get(a, rv);
		check(n, rv, e);
	endtask

	// write a transmit code and wait for the output flop
	task automatic tx_set(input logic [15:0] code);
		wr(`ITS_ADDR_TX, code);
		repeat (2) @(posedge clk_sys);
		#1;
	endtask

	task automatic txc(input logic [15:0] code, input logic [11:0] fl, fh, ll, lh);
		tx_set(code);
		check("tx out", tx_out, {1'b1, fl, fh, ll, lh});
	endtask

	// one tone or dtmf estimate, then read report and event flags
	task automatic sense(input bit dt, input logic [11:0] f1, f2, lv,
		input logic [15:0] cc, st);
		@(posedge clk_sys);
		tone_freq <= f1;
		tone_lvl <= lv;
		lo_f <= f1;
		hi_f <= f2;
		dtmf_lvl <= lv;
		tone_stb <= !dt;
		dtmf_stb <= dt;
		@(posedge clk_sys);
		tone_stb <= 1'b0;
		dtmf_stb <= 1'b0;
		repeat (24) @(posedge clk_sys);
		check("irq pin", irq, st != 16'h0000);
		rd_chk("tone status", `ITS_ADDR_TSTAT, cc);
		rd_chk("irq status", `ITS_ADDR_IRQ, st);
	endtask

	initial begin
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		#1;
		check("tx idle", tx_out, 61'h0);
		rd_chk("irq status", `ITS_ADDR_IRQ, 16'h0000);
		rd_chk("write-only", `ITS_ADDR_MODE, 16'h0000);
		rd_chk("unmapped", 8'h10, 16'h0000);
		for (int c = 0; c < 16; c++) begin
			txc(16'h0400 | 16'(c), LO_TAB[c], HI_TAB[c], 12'h800, 12'h800);
		end
		txc(16'h0501, 12'h2B9, 12'h4B9, 12'h658, 12'h800);
		tx_set(16'h0601);
		check("single low", {tx_out.f_lo, tx_out.lvl_hi}, {12'h2B9, 12'h000});
		tx_set(16'h0608);
		check("single high", {tx_out.f_hi, tx_out.lvl_lo}, {12'h538, 12'h000});
		for (int c = 0; c < 16; c++) begin
			txc(16'h8000 | 16'(c << 11), SEL_TAB[c], 12'h000, 12'h800, 12'h000);
		end
		repeat (50) @(posedge clk_sys);
		check("tx held", {tx_out.on, tx_out.f_lo}, {1'b1, 12'h960});
		tx_set(16'h0000);
		check("tx off", tx_out, 61'h0);
		wr(`ITS_ADDR_MODE, 16'h0301);
		sense(0, 12'h7BD, 12'h000, 12'h200, 16'h8000, 16'h2000);
		sense(0, 12'h83E, 12'h000, 12'h200, 16'hF000, 16'h2000);
		sense(0, 12'h83E, 12'h000, 12'h200, 16'hF000, 16'h0000);
		sense(0, 12'h83E, 12'h000, 12'h010, 16'h0000, 16'h2000);
		sense(0, 12'h464, 12'h000, 12'h200, 16'h8800, 16'h2000);
		sense(1, 12'h2B9, 12'h4B9, 12'h200, 16'h0C00, 16'h1000);
		sense(1, 12'h3AD, 12'h661, 12'h200, 16'h0400, 16'h1000);
		// weak inband strobe and dtmf hit in one cycle
		@(posedge clk_sys);
		tone_lvl <= 12'h010;
		dtmf_lvl <= 12'h200;
		lo_f <= 12'h2B9;
		hi_f <= 12'h4B9;
		tone_stb <= 1'b1;
		dtmf_stb <= 1'b1;
		@(posedge clk_sys);
		tone_stb <= 1'b0;
		dtmf_stb <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rd_chk("dtmf over inband", `ITS_ADDR_TSTAT, 16'h0C00);
		rd_chk("irq status", `ITS_ADDR_IRQ, 16'h3000);
		wr(`ITS_ADDR_PROG, 16'h8012);
		wr(`ITS_ADDR_PROG, 16'h01F4);
		wr(`ITS_ADDR_PROG, 16'h0DAC);
		wr(`ITS_ADDR_PROG, 16'h0120);
		wr(`ITS_ADDR_MODE, 16'h0701);
		sense(0, 12'h1F4, 12'h000, 12'h200, 16'h0800, 16'h2000);
		sense(0, 12'hDAC, 12'h000, 12'h200, 16'h7800, 16'h2000);
		wr(`ITS_ADDR_MODE, 16'h0501);
		sense(0, 12'h120, 12'h000, 12'h200, 16'h1800, 16'h2000);
		sense(0, 12'h7BD, 12'h000, 12'h200, 16'h7800, 16'h2000);
		wr(`ITS_ADDR_MODE, 16'h0E01);
		sense(0, 12'h1F4, 12'h000, 12'h200, 16'h7800, 16'h0000);
		wr(`ITS_ADDR_MODE, 16'h0200);
		sense(0, 12'h464, 12'h000, 12'h200, 16'h8800, 16'h0000);
		wr(`ITS_ADDR_MODE, 16'h0201);
		wr(`ITS_ADDR_PROG, 16'h8003);
		wr(`ITS_ADDR_PROG, 16'h07BD);
		sense(0, 12'h7BD, 12'h000, 12'h200, 16'h8000, 16'h2000);
		wr(`ITS_ADDR_PROG, 16'h8017);
		wr(`ITS_ADDR_PROG, 16'h0300);
		sense(0, 12'h7BD, 12'h000, 12'h200, 16'h0000, 16'h2000);
		wr(`ITS_ADDR_TSTAT, 16'hFFFF);
		rd_chk("read-only", `ITS_ADDR_TSTAT, 16'h0000);
		txc(16'h0800, 12'h1F4, 12'h000, 12'h800, 12'h000);
		tx_set(16'h1000);
		check("refused entry", tx_out.f_lo, 12'h000);
		txc(16'h1800, 12'h120, 12'h000, 12'h800, 12'h000);
		wr(`ITS_ADDR_PROG, 16'h8000);
		wr(`ITS_ADDR_PROG, 16'h0400);
		txc(16'h8000, 12'h7BD, 12'h000, 12'h400, 12'h000);
		stop_test();
	end
endmodule
`default_nettype wire
